// [inc/tx_mod_pkg.sv]
// Purpose: constants, register layouts and carriers of the transmit modulation block
// Assumes: apb with 32-bit data, one aligned word per register, 250 mhz sys_clk
// Notes: register byte address is four times the register index
// Notes on behaviour
// - per-byte framing set: every data byte goes out in its own framed unit.
// - per-byte framing: after a byte, wait for an internal trigger before the next.
// - per-byte framing clear: one start sends all bytes, framed once.
// - modified miller enable applies modified miller pulse coding to the data.
// - pulse position select: none, first quarter, third quarter, last quarter of the bit.
// - envelope invert set inverts the envelope before it leaves the block.
// - envelope select 0h-3h: direct, manchester, manchester with subcarrier, bpsk.
// - envelope select 4h: half-bit pulse at mid-bit; 5h: half-bit pulse at start.
// - envelope applies to the pseudo bit stream; codes 6h and 7h are reserved.
// - upper symbol subcarrier picks 424 or 848 khz for symbols two and three.
// - upper symbol bit rate code 2h-7h picks 26 to 848 khz; 0h,1h reserved.
// - lower symbol subcarrier picks 424 or 848 khz for symbols zero and one.
// - lower symbol bit rate uses the same code table; two lowest codes reserved.
// - pattern zero is a 16-bit value built from a high and a low byte.
package tx_mod_pkg;
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PAT_BITS = 16;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [7:0] IDX_MOD_CTRL = 8'h4b;
  localparam logic [7:0] IDX_SYM_FREQ = 8'h4c;
  localparam logic [7:0] IDX_PAT_HI = 8'h4d;
  localparam logic [7:0] IDX_PAT_LO = 8'h4e;
  localparam logic [7:0] IDX_CMD = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_FILL_LSB = 1;
  localparam logic [2:0] RATE_CODE_26 = 3'h2;
  localparam logic [2:0] RATE_CODE_53 = 3'h3;
  localparam logic [2:0] RATE_CODE_106 = 3'h4;
  localparam logic [2:0] RATE_CODE_212 = 3'h5;
  localparam logic [2:0] RATE_CODE_424 = 3'h6;
  localparam logic [2:0] RATE_CODE_848 = 3'h7;
  localparam int unsigned RATE_KHZ_26 = 26;
  localparam int unsigned RATE_KHZ_53 = 53;
  localparam int unsigned RATE_KHZ_106 = 106;
  localparam int unsigned RATE_KHZ_212 = 212;
  localparam int unsigned RATE_KHZ_424 = 424;
  localparam int unsigned RATE_KHZ_848 = 848;
  localparam int unsigned SC_KHZ_LOW = 424;
  localparam int unsigned SC_KHZ_HIGH = 848;

  typedef enum logic [1:0] {PULSE_NONE, PULSE_START, PULSE_HALF, PULSE_QUARTER3} pulse_sel_t;
  typedef enum logic [2:0] {ENV_DIRECT, ENV_MANCH, ENV_MANCH_SC, ENV_BPSK, ENV_RZ_MID, ENV_RZ_START,
                            ENV_RSV6, ENV_RSV7} env_sel_t;

  typedef struct packed {
    logic per_byte_framing;
    logic modified_miller_enable;
    pulse_sel_t pulse_position_select;
    logic envelope_invert;
    env_sel_t envelope_select;
  } mod_ctrl_t;

  typedef struct packed {
    logic upper_symbol_subcarrier;
    logic [2:0] upper_symbol_bit_rate;
    logic lower_symbol_subcarrier;
    logic [2:0] lower_symbol_bit_rate;
  } sym_freq_t;

  localparam mod_ctrl_t MOD_CTRL_RST = '0;
  localparam sym_freq_t SYM_FREQ_RST = '0;
  localparam logic [PAT_BITS-1:0] PAT_RST = '0;

  typedef struct packed {
    logic [BYTE_BITS-1:0] data;
    logic last;
  } tx_byte_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // reserved codes fall back to 106 khz so a bad setting still gives a sane bit period
  function automatic int unsigned rate_khz(input logic [2:0] code);
    case (code)
      RATE_CODE_26: return RATE_KHZ_26;
      RATE_CODE_53: return RATE_KHZ_53;
      RATE_CODE_212: return RATE_KHZ_212;
      RATE_CODE_424: return RATE_KHZ_424;
      RATE_CODE_848: return RATE_KHZ_848;
      default: return RATE_KHZ_106;
    endcase
  endfunction : rate_khz

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : byte_addr
endpackage : tx_mod_pkg

// [hdl/tx_data_modulation_config.sv]
// Purpose: apb-configured transmit encoder producing the modulated data envelope
// Assumes: inputs synchronous to sys_clk, ce freezes all state
// Notes: sof is pattern zero at the lower symbol rate, eof one zero bit at the upper rate
`timescale 1ns/10ps
`default_nettype none
module tx_data_modulation_config #(
  parameter int unsigned clk_khz = tx_mod_pkg::CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire tx_mod_pkg::apb_req_t apb_req,
  output var tx_mod_pkg::apb_rsp_t apb_rsp,
  input wire tx_mod_pkg::tx_byte_t in_byte,
  input wire logic in_valid,
  output var logic in_ready,
  output var logic tx_envelope,
  output var logic tx_active
);
  import tx_mod_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SOF, ST_LOAD, ST_DATA, ST_EOF, ST_TRIG} fsm_t;
  typedef enum logic [2:0] {SEL_NONE, SEL_MOD, SEL_FREQ, SEL_PHI, SEL_PLO, SEL_CMD, SEL_STAT} sel_t;

  typedef struct packed {
    fsm_t fsm;
    mod_ctrl_t mod_cfg;
    sym_freq_t freq_cfg;
    logic [PAT_BITS-1:0] pat_cfg;
    mod_ctrl_t mod_snap;
    sym_freq_t freq_snap;
    logic [PAT_BITS-1:0] pat_snap;
    tx_byte_t [BUF_DEPTH-1:0] buf_q;
    logic [1:0] buf_cnt;
    logic [PAT_BITS-1:0] shift;
    logic [4:0] bits_left;
    logic last_byte;
    logic prev_bit;
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] sc_cnt;
    logic sc_level;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic env_out;
    logic active;
    logic in_ready;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  function automatic sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    if (addr == byte_addr(IDX_MOD_CTRL))
      return SEL_MOD;
    else if (addr == byte_addr(IDX_SYM_FREQ))
      return SEL_FREQ;
    else if (addr == byte_addr(IDX_PAT_HI))
      return SEL_PHI;
    else if (addr == byte_addr(IDX_PAT_LO))
      return SEL_PLO;
    else if (addr == byte_addr(IDX_CMD))
      return SEL_CMD;
    else if (addr == byte_addr(IDX_STATUS))
      return SEL_STAT;
    else
      return SEL_NONE;
  endfunction : reg_sel

  function automatic logic [CNT_W-1:0] bit_cycles(input logic [2:0] code);
    return CNT_W'(clk_khz / rate_khz(code));
  endfunction : bit_cycles

  function automatic logic [CNT_W-1:0] sc_half_cycles(input logic sc_high);
    return CNT_W'(clk_khz / (2 * (sc_high ? SC_KHZ_HIGH : SC_KHZ_LOW)));
  endfunction : sc_half_cycles

  always_comb
  begin
    sel_t sel;
    logic access;
    logic done;
    logic start;
    logic push;
    logic pop;
    logic upper;
    logic [CNT_W-1:0] bc;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] quarter;
    logic [CNT_W-1:0] sc_half;
    logic win_start;
    logic win_mid;
    logic win_q3;
    logic in_first_half;
    logic cur_bit;
    logic bit_end;
    logic shaped;
    logic pulsed;
    logic base;
    logic sending;
    logic [1:0] cnt_after_pop;
    sel = reg_sel(apb_req.paddr);
    access = apb_req.psel & apb_req.penable;
    done = access & s_r.pready;
    start = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    upper = 1'b0;
    bc = '0;
    half = '0;
    quarter = '0;
    sc_half = '0;
    win_start = 1'b0;
    win_mid = 1'b0;
    win_q3 = 1'b0;
    in_first_half = 1'b0;
    cur_bit = 1'b0;
    bit_end = 1'b0;
    shaped = 1'b0;
    pulsed = 1'b0;
    base = 1'b0;
    sending = 1'b0;
    cnt_after_pop = '0;
    s_nxt = s_r;

    // bus answers one cycle into the access phase; writes land on the completing edge
    s_nxt.pready = access & ~s_r.pready;
    // answer fields drop with pready so a stale error never outlives its cycle
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = '0;
    if (access & ~s_r.pready)
    begin
      s_nxt.pslverr = (sel == SEL_NONE);
      if (!apb_req.pwrite)
      begin
        if (sel == SEL_MOD)
          s_nxt.prdata[7:0] = s_r.mod_cfg;
        else if (sel == SEL_FREQ)
          s_nxt.prdata[7:0] = s_r.freq_cfg;
        else if (sel == SEL_PHI)
          s_nxt.prdata[7:0] = s_r.pat_cfg[PAT_BITS-1:BYTE_BITS];
        else if (sel == SEL_PLO)
          s_nxt.prdata[7:0] = s_r.pat_cfg[BYTE_BITS-1:0];
        else if (sel == SEL_STAT)
        begin
          s_nxt.prdata[STAT_BUSY_BIT] = (s_r.fsm != ST_IDLE);
          s_nxt.prdata[STAT_FILL_LSB +: 2] = s_r.buf_cnt;
        end
      end
    end
    if (done & apb_req.pwrite)
    begin
      if (sel == SEL_MOD)
        s_nxt.mod_cfg = mod_ctrl_t'(apb_req.pwdata[7:0]);
      else if (sel == SEL_FREQ)
        s_nxt.freq_cfg = sym_freq_t'(apb_req.pwdata[7:0]);
      else if (sel == SEL_PHI)
        s_nxt.pat_cfg[PAT_BITS-1:BYTE_BITS] = apb_req.pwdata[7:0];
      else if (sel == SEL_PLO)
        s_nxt.pat_cfg[BYTE_BITS-1:0] = apb_req.pwdata[7:0];
      else if (sel == SEL_CMD)
        start = apb_req.pwdata[CMD_START_BIT];
    end

    // timing of the current segment: eof runs on the upper symbol settings
    upper = (s_r.fsm == ST_EOF);
    bc = upper ? bit_cycles(s_r.freq_snap.upper_symbol_bit_rate)
               : bit_cycles(s_r.freq_snap.lower_symbol_bit_rate);
    sc_half = upper ? sc_half_cycles(s_r.freq_snap.upper_symbol_subcarrier)
                    : sc_half_cycles(s_r.freq_snap.lower_symbol_subcarrier);
    half = bc >> 1;
    quarter = bc >> 2;
    in_first_half = (s_r.phase < half);
    win_start = (s_r.phase < quarter);
    win_mid = (s_r.phase >= half) && (s_r.phase < half + quarter);
    win_q3 = (s_r.phase >= half + quarter);
    cur_bit = s_r.shift[0];
    sending = (s_r.fsm == ST_SOF) || (s_r.fsm == ST_DATA) || (s_r.fsm == ST_EOF);
    bit_end = sending && (s_r.phase == bc - CNT_W'(1));

    // subcarrier runs only while a frame is on air
    if (sending && (s_r.sc_cnt >= sc_half - CNT_W'(1)))
    begin
      s_nxt.sc_cnt = '0;
      s_nxt.sc_level = ~s_r.sc_level;
    end
    else if (sending)
      s_nxt.sc_cnt = s_r.sc_cnt + CNT_W'(1);
    else
    begin
      s_nxt.sc_cnt = '0;
      s_nxt.sc_level = 1'b0;
    end

    // envelope shaping of the pseudo bit stream
    case (s_r.mod_snap.envelope_select)
      ENV_DIRECT: shaped = cur_bit;
      ENV_MANCH: shaped = in_first_half ? cur_bit : ~cur_bit;
      ENV_MANCH_SC: shaped = (in_first_half ? cur_bit : ~cur_bit) & s_r.sc_level;
      ENV_BPSK: shaped = s_r.sc_level ^ ~cur_bit;
      ENV_RZ_MID: shaped = cur_bit & ~in_first_half;
      ENV_RZ_START: shaped = cur_bit & in_first_half;
      default: shaped = cur_bit;
    endcase

    // pulse modulation overrides the envelope shape when selected
    case (s_r.mod_snap.pulse_position_select)
      PULSE_START: pulsed = cur_bit & win_start;
      PULSE_HALF: pulsed = cur_bit & win_mid;
      PULSE_QUARTER3: pulsed = cur_bit & win_q3;
      default: pulsed = 1'b0;
    endcase
    if (s_r.mod_snap.modified_miller_enable)
      pulsed = cur_bit ? win_mid : (~s_r.prev_bit & win_start);
    if (s_r.mod_snap.modified_miller_enable || (s_r.mod_snap.pulse_position_select != PULSE_NONE))
      base = pulsed;
    else
      base = shaped;
    s_nxt.env_out = (sending & base) ^ s_r.mod_snap.envelope_invert;
    s_nxt.active = (s_r.fsm != ST_IDLE);

    // bit engine
    if (sending)
    begin
      s_nxt.phase = bit_end ? '0 : s_r.phase + CNT_W'(1);
      if (bit_end)
      begin
        s_nxt.shift = s_r.shift >> 1;
        s_nxt.prev_bit = cur_bit;
        s_nxt.bits_left = s_r.bits_left - 5'd1;
      end
    end

    case (s_r.fsm)
      ST_IDLE:
      begin
        if (start)
        begin
          s_nxt.mod_snap = s_r.mod_cfg;
          s_nxt.freq_snap = s_r.freq_cfg;
          s_nxt.pat_snap = s_r.pat_cfg;
          s_nxt.shift = s_r.pat_cfg;
          s_nxt.bits_left = 5'(PAT_BITS);
          s_nxt.phase = '0;
          s_nxt.prev_bit = 1'b0;
          s_nxt.fsm = ST_SOF;
        end
      end
      ST_SOF:
      begin
        if (bit_end && (s_r.bits_left == 5'd1))
          s_nxt.fsm = ST_LOAD;
      end
      ST_LOAD:
      begin
        // waits with the field idle until a byte is buffered
        if (s_r.buf_cnt != 2'd0)
        begin
          pop = 1'b1;
          s_nxt.shift = PAT_BITS'(s_r.buf_q[0].data);
          s_nxt.last_byte = s_r.buf_q[0].last;
          s_nxt.bits_left = 5'(BYTE_BITS);
          s_nxt.phase = '0;
          s_nxt.fsm = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (bit_end && (s_r.bits_left == 5'd1))
        begin
          if (s_r.mod_snap.per_byte_framing || s_r.last_byte)
          begin
            s_nxt.shift = '0;
            s_nxt.bits_left = 5'd1;
            s_nxt.fsm = ST_EOF;
          end
          else
            s_nxt.fsm = ST_LOAD;
        end
      end
      ST_EOF:
      begin
        if (bit_end)
        begin
          if (s_r.mod_snap.per_byte_framing && !s_r.last_byte)
            s_nxt.fsm = ST_TRIG;
          else
            s_nxt.fsm = ST_IDLE;
        end
      end
      ST_TRIG:
      begin
        // internal restart trigger: next byte gets its own sof
        s_nxt.shift = s_r.pat_snap;
        s_nxt.bits_left = 5'(PAT_BITS);
        s_nxt.phase = '0;
        s_nxt.fsm = ST_SOF;
      end
      default: s_nxt.fsm = ST_IDLE;
    endcase

    // two-entry buffer: head at index 0
    push = in_valid & s_r.in_ready;
    cnt_after_pop = s_r.buf_cnt - {1'b0, pop};
    if (pop)
      s_nxt.buf_q[0] = s_r.buf_q[1];
    if (push)
      s_nxt.buf_q[cnt_after_pop[0]] = in_byte;
    s_nxt.buf_cnt = cnt_after_pop + {1'b0, push};
    s_nxt.in_ready = (s_nxt.buf_cnt < 2'(BUF_DEPTH));
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.mod_cfg <= MOD_CTRL_RST;
      s_r.freq_cfg <= SYM_FREQ_RST;
      s_r.pat_cfg <= PAT_RST;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  assign apb_rsp = '{prdata: s_r.prdata, pready: s_r.pready, pslverr: s_r.pslverr};
  assign in_ready = s_r.in_ready;
  assign tx_envelope = s_r.env_out;
  assign tx_active = s_r.active;
endmodule : tx_data_modulation_config
`default_nettype wire

// [dv/tx_props.sv]
// Purpose: port checks of the modulation block
// Assumes: ce held high by the bench
// Notes: watches design ports only, inputs as well as outputs
`timescale 1ns/10ps
`default_nettype none
module tx_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire tx_mod_pkg::apb_req_t apb_req,
  input wire tx_mod_pkg::apb_rsp_t apb_rsp,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic tx_envelope,
  input wire logic tx_active
);
  import tx_mod_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  sequence acc_s;
    apb_req.psel && apb_req.penable && ce;
  endsequence
  sequence wait_s;
    !apb_rsp.pready ##1 apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  one_wait_a: assert property (disable iff (srst) $rose(apb_req.penable) ##0 acc_s |-> wait_s)
    else $error("apb answer timing wrong");
  ready_in_access_a: assert property (disable iff (srst) apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("pready outside access");
  write_data_zero_a: assert property (disable iff (srst) apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == '0)
    else $error("prdata set on write");
  upper_bits_zero_a: assert property (disable iff (srst) apb_rsp.pready |-> apb_rsp.prdata[31:8] == '0)
    else $error("upper read bits set");
  err_with_ready_a: assert property (disable iff (srst) apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  refused_read_zero_a: assert property (disable iff (srst) apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == '0)
    else $error("refused read not zero");
  mapped_ok_a: assert property (disable iff (srst) apb_rsp.pready && apb_req.paddr == 12'h12c |-> !apb_rsp.pslverr)
    else $error("mapped register refused");
  // no disable here: the check covers the reset cycles themselves
  reset_quiet_a: assert property (srst |=> !in_ready && !tx_active && !tx_envelope && !apb_rsp.pready)
    else $error("outputs busy after reset");
endmodule : tx_props
`default_nettype wire

// [dv/card_model.sv]
// Purpose: card side, tallies envelope levels seen in a frame
// Assumes: envelope already carries inversion
// Notes: levels between frames carry no data, so are ignored
`timescale 1ns/10ps
`default_nettype none
module card_model (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic tx_envelope,
  input wire logic tx_active,
  output var int on_cnt,
  output var int off_cnt
);
  always_ff @(posedge sys_clk)
  begin
    if (clr)
    begin
      on_cnt <= 0;
      off_cnt <= 0;
    end
    else if (tx_active)
    begin
      on_cnt <= on_cnt + int'(tx_envelope);
      off_cnt <= off_cnt + int'(!tx_envelope);
    end
  end
endmodule : card_model
`default_nettype wire

// [dv/tx_data_modulation_config_tb.sv]
// Purpose: self-checking bench of the modulation block
// Assumes: 848 khz rates and zero pattern during frames
// Notes: clk_khz cut down so bit periods are two cycles
`timescale 1ns/10ps
`default_nettype none
module tx_data_modulation_config_tb;
  import tx_mod_pkg::*;
  localparam int unsigned CLK_K = 2000;
  localparam int BIT_CYC = CLK_K / RATE_KHZ_848;
  localparam int ONES = 16 * BIT_CYC;
  logic sys_clk, srst, ce, in_valid, in_ready, tx_envelope, tx_active, clr;
  apb_req_t req;
  apb_rsp_t rsp;
  tx_byte_t in_byte;
  int on_cnt, off_cnt, n_errors, checked, act1, act2;
  tx_data_modulation_config #(.clk_khz(CLK_K)) tx_data_modulation_config_inst (.sys_clk(sys_clk), .srst(srst),
    .ce(ce), .apb_req(req), .apb_rsp(rsp), .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
    .tx_envelope(tx_envelope), .tx_active(tx_active));
  card_model card_model_inst (.sys_clk(sys_clk), .clr(clr), .tx_envelope(tx_envelope),
    .tx_active(tx_active), .on_cnt(on_cnt), .off_cnt(off_cnt));
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int i;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, ADDR_W'({idx, 2'b00}), wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (rsp.pready !== 1'b1 && i < 50);
    if (i == 50)
      n_errors++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, '0, d, e);
    chk(d, exp);
  endtask : rdchk
  task automatic push(input logic [7:0] d, input logic last);
    int i;
    @(posedge sys_clk);
    in_byte <= '{d, last};
    in_valid <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (in_ready !== 1'b1 && i < 200);
    if (in_ready !== 1'b1)
      n_errors++;
    in_valid <= 1'b0;
  endtask : push
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    logic [7:0] v;
    for (int k = 0; k < 4; k++)
      rdchk(IDX_MOD_CTRL + 8'(k), 32'h0);
    for (int k = 0; k < 6; k++)
    begin
      v = {k[0], 1'b0, k[1:0], k[1], k[2:0]};
      wr(IDX_MOD_CTRL, {24'h0, v});
      rdchk(IDX_MOD_CTRL, {24'h0, v});
      v = {k[0], 3'(k + 2), k[1], 3'(k + 2)};
      wr(IDX_SYM_FREQ, {24'h0, v});
      rdchk(IDX_SYM_FREQ, {24'h0, v});
    end
    wr(IDX_MOD_CTRL, 32'h51);
    rdchk(IDX_MOD_CTRL, 32'h51);
    apb(1'b0, 8'h10, '0, d, e);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    wr(IDX_SYM_FREQ, 32'h77);
  endtask : t_regs
  task automatic frame(input logic [7:0] ctrl, input logic mid, output int act);
    int q;
    wr(IDX_MOD_CTRL, {24'h0, ctrl});
    push(8'hff, 1'b0);
    push(8'hff, 1'b1);
    @(posedge sys_clk);
    chk({31'h0, in_ready}, 32'h0);
    clr <= 1'b1;
    wr(IDX_CMD, 32'h1);
    clr <= 1'b0;
    if (mid)
      wr(IDX_MOD_CTRL, {24'h0, ctrl ^ 8'h08});
    q = 0;
    for (int i = 0; i < 2000 && q < 12; i++)
    begin
      @(posedge sys_clk);
      q = tx_active ? 0 : q + 1;
    end
    act = on_cnt + off_cnt;
    rdchk(IDX_STATUS, 32'h0);
  endtask : frame
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #40000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    req = '0;
    in_byte = '0;
    in_valid = 1'b0;
    clr = 1'b0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    frame(8'h00, 1'b1, act1);
    chk(32'(on_cnt), 32'(ONES));
    frame(8'h08, 1'b0, act2);
    chk(32'(off_cnt), 32'(ONES));
    frame(8'h80, 1'b0, act2);
    chk(32'(on_cnt), 32'(ONES));
    chk({31'h0, act2 >= act1 + 17 * BIT_CYC}, 32'h1);
    frame(8'h01, 1'b0, act2);
    chk(32'(on_cnt), 32'((PAT_BITS + 2 * BYTE_BITS + 1) * BIT_CYC / 2));
    frame(8'h05, 1'b0, act2);
    chk(32'(on_cnt), 32'(ONES / 2));
    frame(8'h04, 1'b0, act2);
    chk(32'(on_cnt), 32'(ONES / 2));
    end_of_test();
  end
endmodule : tx_data_modulation_config_tb
bind tx_data_modulation_config tx_props tx_props_inst (.sys_clk(sys_clk), .srst(srst), .ce(ce),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .in_valid(in_valid), .in_ready(in_ready),
  .tx_envelope(tx_envelope), .tx_active(tx_active));
`default_nettype wire
